//--- logic/plc_pkg.sv
// Package for the port lock and low-power configuration register bank
package plc_pkg;
	localparam logic [15:0] PLC_ADDR_LEVEL = 16'hEC00;
	localparam logic [15:0] PLC_ADDR_CONFIG = 16'hEC01;
	localparam int PLC_THR_LSB = 0;
	localparam int PLC_THR_W = 3;
	localparam int PLC_PER_LSB = 3;
	localparam int PLC_PER_W = 5;
	localparam int PLC_REFSEL_BIT = 0;
	localparam int PLC_LOCK_BIT = 1;
	localparam logic [2:0] PLC_THR_RESET = 3'h7;
	localparam logic [4:0] PLC_PER_RESET = 5'h00;
	localparam logic PLC_REFSEL_RESET = 1'b0;
	localparam logic [1:0] PLC_TOGGLES_TO_SPI = 2'h3;
	localparam int PLC_THR_DIVISOR = 8;
	localparam int PLC_PERIOD_DIVISOR = 50;

	typedef struct packed {
		logic we;
		logic re;
		logic [15:0] addr;
		logic [7:0] wdata;
	} plc_req_t;

	typedef enum logic {PLC_PORT_I2C, PLC_PORT_SPI} plc_port_t;
endpackage

//--- logic/plc_config_regs.sv
// Low-power threshold and secondary configuration registers with serial port lock
// Operation
// R1 - Threshold field bits 2:0, reset 111, threshold is full scale times value over 8
// R2 - Period field bits 7:3, reset 0, period is (value plus one)/50 seconds
// R3 - Threshold register exists only with neutral channel, otherwise reserved
// R4 - Reference-select bit 0 resets 0; 0 internal, 1 external reference
// R5 - While unlocked, three select pin toggles switch port from I2C to SPI
// R6 - An I2C host writes one to the lock bit to keep I2C
// R7 - Locked while on I2C, pin toggles are ignored and SPI never selected
// R8 - On SPI, any write to the secondary register locks the port
// R9 - Locked port choice survives power mode changes
// R10 - Bits 7:2 of the secondary register are reserved, read zero
// R11 - Lock clears only on device reset
`timescale 1ns/1ns
`default_nettype none
module plc_config_regs
	import plc_pkg::*;
#(
	parameter bit HAS_NEUTRAL = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire plc_req_t req,
	output logic [7:0] rdata,
	input wire logic slave_select_ack_pin,
	input wire logic [1:0] power_mode_states,
	output logic [2:0] overcurrent_threshold_field,
	output logic [4:0] lowpower_period_field,
	output logic reference_select_bit,
	output logic port_locked,
	output logic spi_active
);
	logic lock;
	logic next_lock;
	plc_port_t port;
	plc_port_t next_port;
	logic [1:0] toggles;
	logic [1:0] next_toggles;
	logic pin_prev;
	logic pin_edge;
	logic write_level;
	logic write_config;
	logic read_level;
	logic read_config;
	logic count_enable;
	logic [2:0] next_threshold;
	logic [4:0] next_period;
	logic next_refsel;
	logic [7:0] next_rdata;

	// Address decode shared by the write and read paths
	function automatic logic is_level_addr(
		input logic [15:0] addr
	);
		return HAS_NEUTRAL && (addr == PLC_ADDR_LEVEL); // [R3]
	endfunction

	function automatic logic is_config_addr(
		input logic [15:0] addr
	);
		return addr == PLC_ADDR_CONFIG;
	endfunction

	function automatic logic [7:0] level_word(
		input logic [4:0] period,
		input logic [2:0] threshold
	);
		return {period, threshold};
	endfunction

	function automatic logic [7:0] config_word(
		input logic locked,
		input logic refsel
	);
		// Reserved upper bits carry no state, so they always read back as zero
		return {6'h00, locked, refsel}; // [R10]
	endfunction

	assign write_level = req.we && is_level_addr(req.addr); // [R3]
	assign write_config = req.we && is_config_addr(req.addr);
	assign read_level = req.re && is_level_addr(req.addr); // [R3]
	assign read_config = req.re && is_config_addr(req.addr);
	assign pin_edge = (slave_select_ack_pin != pin_prev);
	// Once locked, toggles no longer count, so a glitchy pin cannot move the port
	assign count_enable = !lock && pin_edge; // [R7]

	always_comb begin
		next_threshold = overcurrent_threshold_field;
		if (write_level) begin
			next_threshold = req.wdata[PLC_THR_LSB +: PLC_THR_W]; // [R1]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			overcurrent_threshold_field <= PLC_THR_RESET; // [R1]
		end else begin
			overcurrent_threshold_field <= next_threshold;
		end
	end

	always_comb begin
		next_period = lowpower_period_field;
		if (write_level) begin
			next_period = req.wdata[PLC_PER_LSB +: PLC_PER_W]; // [R2]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			lowpower_period_field <= PLC_PER_RESET; // [R2]
		end else begin
			lowpower_period_field <= next_period;
		end
	end

	always_comb begin
		next_refsel = reference_select_bit;
		if (write_config) begin
			next_refsel = req.wdata[PLC_REFSEL_BIT]; // [R4]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reference_select_bit <= PLC_REFSEL_RESET; // [R4]
		end else begin
			reference_select_bit <= next_refsel;
		end
	end

	// Power mode input is deliberately unused: lock and port hold across modes
	always_comb begin
		next_lock = lock;
		if (write_config) begin
			unique case (port)
				PLC_PORT_SPI: begin
					next_lock = 1'b1; // [R8]
				end
				PLC_PORT_I2C: begin
					// A zero in the lock bit leaves the lock alone; only reset clears it
					next_lock = lock | req.wdata[PLC_LOCK_BIT]; // [R6] [R7] [R11]
				end
			endcase
		end
	end // [R9]

	always_ff @(posedge clk) begin
		if (reset) begin
			lock <= 1'b0; // [R11]
		end else begin
			lock <= next_lock;
		end
	end

	// Pin history starts at the idle high level, so release of reset makes no edge
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= slave_select_ack_pin;
		end
	end

	always_comb begin
		next_port = port;
		next_toggles = toggles;
		unique case (port)
			PLC_PORT_I2C: begin
				if (count_enable) begin
					if (toggles == PLC_TOGGLES_TO_SPI - 2'h1) begin
						next_port = PLC_PORT_SPI; // [R5]
						next_toggles = 2'h0;
					end else begin
						next_toggles = toggles + 2'h1; // [R5]
					end
				end
			end
			PLC_PORT_SPI: begin
				// No route back to I2C exists in this block
				next_port = PLC_PORT_SPI; // [R8] [R9]
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			port <= PLC_PORT_I2C;
		end else begin
			port <= next_port;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			toggles <= 2'h0;
		end else begin
			toggles <= next_toggles;
		end
	end

	always_comb begin
		next_rdata = rdata;
		if (read_level) begin
			next_rdata = level_word(lowpower_period_field, overcurrent_threshold_field);
		end else if (read_config) begin
			next_rdata = config_word(lock, reference_select_bit);
		end else if (req.re) begin
			// Unmapped and reserved addresses read as zero
			next_rdata = 8'h00; // [R3]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign port_locked = lock;
	assign spi_active = (port == PLC_PORT_SPI);
endmodule // plc_config_regs
`default_nettype wire

//--- sim/plc_monitor.sv
// Checker for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module plc_monitor
	import plc_pkg::*;
#(
	parameter bit HAS_NEUTRAL = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire plc_req_t req,
	input wire logic [7:0] rdata,
	input wire logic [1:0] power_mode_states,
	input wire logic [2:0] overcurrent_threshold_field,
	input wire logic [4:0] lowpower_period_field,
	input wire logic reference_select_bit,
	input wire logic port_locked,
	input wire logic spi_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire wl = req.we && HAS_NEUTRAL && req.addr == PLC_ADDR_LEVEL;
	wire rl = req.re && req.addr == PLC_ADDR_LEVEL;
	wire wc = req.we && req.addr == PLC_ADDR_CONFIG;
	wire [7:0] lvl = {lowpower_period_field, overcurrent_threshold_field};
	wire [7:0] cfg = {6'h00, port_locked, reference_select_bit};
	wire [7:0] lvl_read = HAS_NEUTRAL ? lvl : 8'h00;
	a_level_wr: assert property (wl |=> lvl == $past(req.wdata))
		else $error("level");
	a_ref_wr: assert property (wc |=> reference_select_bit == $past(req.wdata[0]))
		else $error("ref");
	a_spi_lock: assert property (wc && spi_active |=> port_locked)
		else $error("lock");
	a_lock_hold: assert property (port_locked |=> port_locked && $stable(spi_active))
		else $error("hold");
	a_spi_unlocked: assert property ($rose(spi_active) |-> !$past(port_locked))
		else $error("spi");
	a_rd_level: assert property (rl |=> rdata == $past(lvl_read))
		else $error("rl");
	a_rd_config: assert property (req.re && req.addr == PLC_ADDR_CONFIG |=> rdata == $past(cfg))
		else $error("rc");
	a_cfg_apart: assert property (wc |=> $stable(lvl))
		else $error("iso");
	a_mode_keep: assert property (port_locked && $changed(power_mode_states) |=> $stable(spi_active))
		else $error("mode");
	cover property (port_locked && spi_active);
	cover property (port_locked && !spi_active);
	cover property (wl);
	cover property ($rose(spi_active));
endmodule // plc_monitor
bind plc_config_regs plc_monitor #(.HAS_NEUTRAL(HAS_NEUTRAL)) plc_monitor_inst (
	.clk(clk),
	.reset(reset),
	.req(req),
	.rdata(rdata),
	.power_mode_states(power_mode_states),
	.overcurrent_threshold_field(overcurrent_threshold_field),
	.lowpower_period_field(lowpower_period_field),
	.reference_select_bit(reference_select_bit),
	.port_locked(port_locked),
	.spi_active(spi_active)
);
`default_nettype wire

//--- sim/plc_host.sv
// Host controller model: register strobes and the select pin
`timescale 1ns/1ns
`default_nettype none
module plc_host
	import plc_pkg::*;
(
	input wire logic clk,
	output var plc_req_t req,
	output logic pin
);
	initial begin req = '0; pin = 1'b1; end
	// One strobe cycle per access; the idle edge after it keeps calls apart
	task wr(input logic [15:0] a, input logic [7:0] d); @(posedge clk) req <= '{1'b1, 1'b0, a, d}; @(posedge clk) req.we <= 1'b0; #1; endtask
	task rd(input logic [15:0] a); @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00}; @(posedge clk) req.re <= 1'b0; #1; endtask
	task tog; @(posedge clk) pin <= ~pin; endtask
endmodule // plc_host
`default_nettype wire

//--- sim/testbench.sv
// Testbench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module testbench import plc_pkg::*; ;
	logic clk = 1'b0, reset = 1'b1, pin, lk, spi, rs;
	logic [1:0] pm = 2'h0;
	logic [2:0] thr;
	logic [4:0] per;
	logic [7:0] rdv;
	plc_req_t req;
	int n_errors = 0, checked = 0;
	initial forever #25 clk = ~clk;
	plc_host plc_host_inst (.clk(clk), .req(req), .pin(pin));
	plc_config_regs plc_config_regs_inst (.clk(clk), .reset(reset), .req(req), .rdata(rdv),
		.slave_select_ack_pin(pin), .power_mode_states(pm), .overcurrent_threshold_field(thr),
		.lowpower_period_field(per), .reference_select_bit(rs), .port_locked(lk), .spi_active(spi));
	task chk(input logic [7:0] g, e); checked++; if (g !== e) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end endtask
	task wrap_up; if (n_errors == 0 && checked > 0) $display("TB: PASS"); else $display("TB: FAIL"); $finish; endtask
	task do_reset; @(posedge clk) reset <= 1'b1; repeat (15) @(posedge clk); reset <= 1'b0; @(posedge clk) #1; endtask
	task t_defaults;
		chk({per, thr}, 8'h07);
		chk({5'h00, lk, spi, rs}, 8'h00);
		plc_host_inst.rd(PLC_ADDR_CONFIG);
		chk(rdv, 8'h00);
	endtask
	task t_level;
		plc_host_inst.wr(PLC_ADDR_LEVEL, 8'hA5);
		chk({per, thr}, 8'hA5);
		plc_host_inst.rd(PLC_ADDR_LEVEL);
		chk(rdv, 8'hA5);
	endtask
	// Four toggles leave the pin high again before the next reset
	task t_i2c;
		plc_host_inst.wr(PLC_ADDR_CONFIG, 8'hFF);
		repeat (4) plc_host_inst.tog();
		plc_host_inst.wr(PLC_ADDR_CONFIG, 8'h00);
		plc_host_inst.rd(PLC_ADDR_CONFIG);
		chk(rdv, 8'h02);
		chk({7'h00, spi}, 8'h00);
	endtask
	task t_spi;
		repeat (3) plc_host_inst.tog();
		repeat (2) @(posedge clk);
		#1 chk({7'h00, spi}, 8'h01);
		plc_host_inst.wr(PLC_ADDR_CONFIG, 8'h01);
		@(posedge clk) pm <= 2'h2;
		repeat (2) @(posedge clk);
		#1 chk({5'h00, lk, spi, rs}, 8'h07);
	endtask
	initial begin do_reset(); t_defaults(); t_level(); t_i2c(); do_reset(); t_spi(); wrap_up(); end
endmodule // testbench
`default_nettype wire
